// [design/ladder_bit_output_oneshot.sv]
`timescale 1ns/100ps
`default_nettype none
module ladder_bit_output_oneshot (
	input  wire logic                               core_clk_i,
	input  wire logic                               arst_n_i,
	input  wire logic [ladder_bit_pkg::ADDR_W-1:0]  addr_i,
	input  wire logic [ladder_bit_pkg::DATA_W-1:0]  wdata_i,
	input  wire logic                               wr_i,
	input  wire logic                               rd_i,
	output logic      [ladder_bit_pkg::DATA_W-1:0]  rdata_o,
	input  wire logic                               power_good_i,
	input  wire logic                               fault_i,
	output logic      [ladder_bit_pkg::PHYS_OUTS-1:0] phys_out_o
);
	import ladder_bit_pkg::*;

	//------------------------------------------------------------------
	// Decoding helpers
	//------------------------------------------------------------------
	function automatic logic [TABLE_BITS-1:0] bit_mask(
		input logic [BIT_ADDR_W-1:0] idx
	);
		logic [TABLE_BITS-1:0] m;
		m = '0;
		m[idx] = 1'b1;
		return m;
	endfunction

	function automatic logic [TABLE_BITS-1:0] put_bit(
		input logic [TABLE_BITS-1:0] tbl,
		input logic [BIT_ADDR_W-1:0] idx,
		input logic                  val
	);
		return val ? (tbl | bit_mask(idx)) : (tbl & ~bit_mask(idx));
	endfunction

	//------------------------------------------------------------------
	// State
	//------------------------------------------------------------------
	logic [TABLE_BITS-1:0] data_table;
	logic [TABLE_BITS-1:0] next_table;
	logic [TABLE_BITS-1:0] coil_owned;
	logic [TABLE_BITS-1:0] next_coil_owned;
	logic                  rung_out;
	logic                  next_rung_out;
	logic                  prog_mode;
	logic                  prog_mode_d;
	logic                  power_d;
	logic [1:0]            settle;
	logic [1:0]            pins_sync;
	logic                  power_sync;
	logic                  fault_sync;
	logic                  clear_event;
	logic                  exec;
	logic [BIT_ADDR_W-1:0] op_addr;
	logic [BIT_ADDR_W-1:0] store_addr;
	logic                  rung_in;
	logic                  zone_true;
	logic                  eff_rung;
	opcode_t               op;

	level_sync #(
		.WIDTH (2)
	) u_pin_sync (
		.core_clk_i (core_clk_i),
		.arst_n_i   (arst_n_i),
		.async_i    ({fault_i, power_good_i}),
		.sync_o     (pins_sync)
	);

	assign power_sync = pins_sync[0];
	assign fault_sync = pins_sync[1];

	//------------------------------------------------------------------
	// Instruction decode
	//------------------------------------------------------------------
	assign exec       = wr_i && (addr_i == REG_EXECUTE) && !prog_mode;
	assign op_addr    = wdata_i[EX_ADDR_LSB +: BIT_ADDR_W];
	assign store_addr = wdata_i[EX_STORE_LSB +: BIT_ADDR_W];
	assign rung_in    = wdata_i[EX_RUNG_POS];
	assign zone_true  = wdata_i[EX_ZONE_POS];
	assign op         = opcode_t'(wdata_i[EX_OP_LSB +: 3]);
	// A false control zone makes every rung inside it false.
	assign eff_rung   = rung_in && zone_true;

	// Mode entry and power return both wipe non-retentive bits; the
	// edge detectors read only fully synchronised levels.
	assign clear_event = (prog_mode && !prog_mode_d)
		|| (power_sync && !power_d);

	//------------------------------------------------------------------
	// Instruction execution
	//------------------------------------------------------------------
	always_comb begin
		next_table      = data_table;
		next_coil_owned = coil_owned;
		next_rung_out   = rung_out;
		if (exec) begin
			unique case (op)
				op_output_coil: begin
					next_table = put_bit(data_table, op_addr,
						eff_rung);
					next_coil_owned = coil_owned | bit_mask(op_addr);
					next_rung_out   = eff_rung;
				end
				op_latch_set: begin
					if (eff_rung) begin
						next_table = put_bit(data_table, op_addr,
							1'b1);
						next_coil_owned = coil_owned & ~bit_mask(op_addr);
					end
					next_rung_out = eff_rung;
				end
				op_latch_clear: begin
					if (eff_rung) begin
						next_table = put_bit(data_table, op_addr,
							1'b0);
						next_coil_owned = coil_owned & ~bit_mask(op_addr);
					end
					next_rung_out = eff_rung;
				end
				op_rising_one_shot: begin
					// The storage bit remembers the previous rung.
					next_table = put_bit(data_table, store_addr,
						eff_rung);
					next_rung_out = eff_rung
						&& !data_table[store_addr];
				end
				op_examine_on: begin
					next_rung_out = eff_rung
						&& data_table[op_addr];
				end
				op_examine_off: begin
					next_rung_out = eff_rung
						&& !data_table[op_addr];
				end
				default: begin
					next_rung_out = 1'b0;
				end
			endcase
		end
		if (clear_event) begin
			next_table = next_table & ~next_coil_owned;
		end
	end

	// The new value is visible to the very next instruction.
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			data_table <= TABLE_RESET;
			coil_owned <= TABLE_RESET;
			rung_out   <= 1'b0;
		end else begin
			data_table <= next_table;
			coil_owned <= next_coil_owned;
			rung_out   <= next_rung_out;
		end
	end

	//------------------------------------------------------------------
	// Mode and edge history
	//------------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prog_mode <= 1'b0;
		end else if (wr_i && addr_i == REG_CONTROL) begin
			prog_mode <= wdata_i[CTL_PROG_POS];
		end
	end

	// The synchroniser leaves reset low, so its first rise is no power
	// return; the history stays high until both stages hold the pin.
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prog_mode_d <= 1'b0;
			power_d     <= 1'b1;
			settle      <= 2'b00;
		end else begin
			prog_mode_d <= prog_mode;
			power_d     <= settle[1] ? power_sync : 1'b1;
			settle      <= {settle[0], 1'b1};
		end
	end

	//------------------------------------------------------------------
	// Physical outputs
	//------------------------------------------------------------------
	// The data table is left intact under a fault, so outputs come
	// back with the held values one clock after the synchronised fault clears.
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			phys_out_o <= OUTS_RESET;
		end else if (fault_sync) begin
			phys_out_o <= OUTS_RESET;
		end else begin
			phys_out_o <= data_table[PHYS_OUTS-1:0];
		end
	end

	//------------------------------------------------------------------
	// Register read
	//------------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= RDATA_RESET;
		end else if (rd_i) begin
			rdata_o <= RDATA_RESET;
			unique case (addr_i)
				REG_CONTROL: begin
					rdata_o[CTL_PROG_POS] <= prog_mode;
				end
				REG_STATUS: begin
					rdata_o[ST_RUNG_POS] <= rung_out;
					rdata_o[ST_ERR_POS]  <= fault_sync;
					rdata_o[ST_PROG_POS] <= prog_mode;
				end
				REG_TABLE_LO: begin
					rdata_o <= data_table[31:0];
				end
				REG_TABLE_HI: begin
					rdata_o <= data_table[63:32];
				end
				default: begin
					rdata_o <= RDATA_RESET;
				end
			endcase
		end else begin
			rdata_o <= RDATA_RESET;
		end
	end
endmodule
`default_nettype wire

// [design/ladder_bit_pkg.sv]
//------------------------------------------------------------------
//------------------------------------------------------------------
`default_nettype none
package ladder_bit_pkg;

	//------------------------------------------------------------------
	// Register bus
	//------------------------------------------------------------------
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;
	localparam logic [7:0]  REG_CONTROL   = 8'h00;
	localparam logic [7:0]  REG_EXECUTE   = 8'h04;
	localparam logic [7:0]  REG_STATUS    = 8'h08;
	localparam logic [7:0]  REG_TABLE_LO  = 8'h0C;
	localparam logic [7:0]  REG_TABLE_HI  = 8'h10;

	//------------------------------------------------------------------
	// Data table and outputs
	//------------------------------------------------------------------
	localparam int          TABLE_BITS    = 64;
	localparam int          BIT_ADDR_W    = 6;
	localparam int          PHYS_OUTS     = 8;

	//------------------------------------------------------------------
	// Field positions
	//------------------------------------------------------------------
	localparam int          CTL_PROG_POS  = 0;
	localparam int          EX_ADDR_LSB   = 0;
	localparam int          EX_STORE_LSB  = 8;
	localparam int          EX_RUNG_POS   = 16;
	localparam int          EX_ZONE_POS   = 17;
	localparam int          EX_OP_LSB     = 20;
	localparam int          ST_RUNG_POS   = 0;
	localparam int          ST_ERR_POS    = 1;
	localparam int          ST_PROG_POS   = 2;

	//------------------------------------------------------------------
	// Reset values
	//------------------------------------------------------------------
	localparam logic [63:0] TABLE_RESET   = 64'h0000_0000_0000_0000;
	localparam logic [7:0]  OUTS_RESET    = 8'h00;
	localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;

	typedef enum logic [2:0] {
		op_output_coil,
		op_latch_set,
		op_latch_clear,
		op_rising_one_shot,
		op_examine_on,
		op_examine_off
	} opcode_t;

endpackage
`default_nettype wire

// [design/level_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module level_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             core_clk_i,
	input  wire logic             arst_n_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage1;

	// The first stage feeds the second stage only.
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stage1 <= '0;
			sync_o <= '0;
		end else begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end
endmodule
`default_nettype wire

// [tb/ladder_bit_props.sv]
`timescale 1ns/100ps
`default_nettype none
module ladder_bit_props (
	input wire logic        core_clk_i,
	input wire logic        arst_n_i,
	input wire logic [7:0]  addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic        power_good_i,
	input wire logic        fault_i,
	input wire logic [7:0]  phys_out_o
);
	import ladder_bit_pkg::*;
	logic        prog_q;
	logic [31:0] w1;
	logic [31:0] w2;
	wire         ex_w  = wr_i && addr_i == REG_EXECUTE && !prog_q;
	wire [2:0]   op    = wdata_i[22:20];
	wire         eff   = wdata_i[16] && wdata_i[17];
	wire         os_t  = ex_w && op == 3'd3 && eff;
	wire         os_f  = ex_w && op == 3'd3 && !eff;
	wire         same  = wdata_i[13:8] == w1[13:8];
	wire         rd_st = rd_i && addr_i == REG_STATUS;
	wire         rd_lo = rd_i && addr_i == REG_TABLE_LO;
	// Executes in program mode are refused, so the mode is mirrored here.
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			prog_q <= 1'b0;
		else if (wr_i && addr_i == REG_CONTROL)
			prog_q <= wdata_i[0];
	end
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			w1 <= 32'h0000_0000;
			w2 <= 32'h0000_0000;
		end else begin
			w1 <= wdata_i;
			w2 <= w1;
		end
	end
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	property p_coil;
		power_good_i [*8] ##0 (ex_w && op == 3'd0 && !wdata_i[5]) ##1 rd_lo
			|=> rdata_o[w2[4:0]] == (w2[16] && w2[17]);
	endproperty
	a_coil: assert property (p_coil) else $error("coil");
	property p_latch;
		(ex_w && (op == 3'd1 || op == 3'd2) && eff && !wdata_i[5]) ##1 rd_lo
			|=> rdata_o[w2[4:0]] == (w2[22:20] == 3'd1);
	endproperty
	a_latch: assert property (p_latch) else $error("latch");
	property p_once;
		os_f ##1 (os_t && same) ##1 rd_st |=> rdata_o[0];
	endproperty
	a_once: assert property (p_once) else $error("once");
	property p_hold;
		os_t ##1 (os_t && same) ##1 rd_st |=> !rdata_o[0];
	endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_false;
		(ex_w && op >= 3'd3 && op <= 3'd5 && !eff) ##1 rd_st |=> !rdata_o[0];
	endproperty
	a_false: assert property (p_false) else $error("false");
	property p_fault;
		fault_i [*4] |=> phys_out_o == 8'h00;
	endproperty
	a_fault: assert property (p_fault) else $error("fault");
	property p_follow;
		(!fault_i) [*5] ##0 rd_lo |=> phys_out_o == rdata_o[7:0];
	endproperty
	a_follow: assert property (p_follow) else $error("follow");
	property p_idle;
		!rd_i |=> rdata_o == 32'h0000_0000;
	endproperty
	a_idle: assert property (p_idle) else $error("idle");
	property p_next;
		power_good_i [*8] ##0 (ex_w && op == 3'd0 && eff) ##1 (ex_w
			&& op == 3'd4 && eff && wdata_i[5:0] == w1[5:0]) ##1 rd_st
			|=> rdata_o[0];
	endproperty
	a_next: assert property (p_next) else $error("next");
endmodule
bind ladder_bit_output_oneshot ladder_bit_props chk_u (.core_clk_i, .arst_n_i,
	.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .power_good_i, .fault_i,
	.phys_out_o);
`default_nettype wire

// [tb/tb_ladder_bit_output_oneshot.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_ladder_bit_output_oneshot;
	import ladder_bit_pkg::*;
	logic        core_clk_i = 1'b0, arst_n_i = 1'b0, power_good_i = 1'b1;
	logic        wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0, fault_i = 1'b0;
	logic        ph_req = 1'b0;
	logic [7:0]  phys_q[$];
	logic [7:0]  addr_i = 8'h00, phys_out_o;
	logic [31:0] wdata_i = 32'h0000_0000, rdata_o, r = 32'h3194_a320;
	logic [63:0] tbl = '0, own = '0;
	logic        res = 1'b0, prog = 1'b0;
	logic [31:0] exp_q[$];
	int          err_count = 0, cmp_count = 0;
	always #2 core_clk_i = ~core_clk_i;
	ladder_bit_output_oneshot dut_u (.core_clk_i, .arst_n_i, .addr_i,
		.wdata_i, .wr_i, .rd_i, .rdata_o, .power_good_i, .fault_i,
		.phys_out_o);
	task automatic chk(input string n, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_phys(input logic [7:0] e, g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED phys expected %h seen %h", e, g);
		end
	endtask
	task automatic note_phys(input logic [7:0] e);
		phys_q.push_back(e);
		ph_req <= 1'b1;
		@(posedge core_clk_i);
		ph_req <= 1'b0;
	endtask
	task automatic conclude;
		if (err_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function automatic logic [31:0] st(input logic f);
		return {29'h0, prog, f, res};
	endfunction
	task automatic bus(input logic w, q, input logic [7:0] a,
		input logic [31:0] d);
		wr_i <= w;
		rd_i <= q;
		addr_i <= a;
		wdata_i <= d;
		@(posedge core_clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, 1'b1, a, 32'h0000_0000);
	endtask
	task automatic idle(input int n);
		repeat (n) bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
	endtask
	// Reference model of one instruction; refused while in program mode.
	// Operands are plain bit numbers, never indirect, and no instruction
	// here enables interrupts, so rung ordering is free.
	task automatic ex(input logic [2:0] op, input logic [5:0] a, s,
		input logic rg, zn);
		logic e;
		e = rg & zn;
		bus(1'b1, 1'b0, REG_EXECUTE, {9'h0, op, 2'b0, zn, rg, 2'b0, s, 2'b0, a});
		if (!prog) case (op)
			3'd0: begin
				tbl[a] = e;
				own[a] = 1'b1;
				res = e;
			end
			3'd1, 3'd2: begin
				if (e) tbl[a] = (op == 3'd1);
				if (e) own[a] = 1'b0;
				res = e;
			end
			3'd3: begin
				res = e & !tbl[s];
				tbl[s] = e;
			end
			3'd4: res = e & tbl[a];
			default: res = e & !tbl[a];
		endcase
	endtask
	always @(posedge core_clk_i) begin
		if (rd_d) chk("rdata", exp_q.pop_front(), rdata_o);
		if (ph_req) chk_phys(phys_q.pop_front(), phys_out_o);
		rd_d <= rd_i;
	end
	initial begin
		#40_000;
		err_count++;
		conclude();
	end
	initial begin
		repeat (6) @(posedge core_clk_i);
		arst_n_i <= 1'b1;
		@(posedge core_clk_i);
		for (int k = 0; k < 6; k++) rd(8'(k * 4), 32'h0000_0000);
		ex(3'd1, 6'd3, 6'd40, 1'b1, 1'b1);
		ex(3'd0, 6'd2, 6'd40, 1'b1, 1'b1);
		ex(3'd1, 6'd3, 6'd40, 1'b0, 1'b1);
		rd(REG_TABLE_LO, tbl[31:0]);
		power_good_i <= 1'b0;
		idle(5);
		power_good_i <= 1'b1;
		tbl &= ~own;
		idle(6);
		note_phys(tbl[7:0]);
		rd(REG_TABLE_LO, tbl[31:0]);
		ex(3'd0, 6'd2, 6'd40, 1'b1, 1'b1);
		bus(1'b1, 1'b0, REG_CONTROL, 32'h0000_0001);
		prog = 1'b1;
		tbl &= ~own;
		idle(3);
		ex(3'd0, 6'd5, 6'd40, 1'b1, 1'b1);
		rd(REG_TABLE_LO, tbl[31:0]);
		rd(REG_CONTROL, 32'h0000_0001);
		bus(1'b1, 1'b0, REG_CONTROL, 32'h0000_0000);
		prog = 1'b0;
		fault_i <= 1'b1;
		idle(5);
		note_phys(8'h00);
		rd(REG_STATUS, st(1'b1));
		fault_i <= 1'b0;
		idle(5);
		note_phys(tbl[7:0]);
		ex(3'd0, 6'd6, 6'd40, 1'b1, 1'b1);
		ex(3'd4, 6'd6, 6'd40, 1'b1, 1'b1);
		rd(REG_STATUS, st(1'b0));
		// One-shot storage sits at 40 or 41, clear of the operand range.
		for (int i = 0; i < 300; i++) begin
			repeat (2) begin
				r = xs(r);
				ex(r[2:0] > 3'd5 ? 3'd3 : r[2:0], 6'(r[8:3] % 6'd40),
					{5'h14, r[9]}, r[10], r[11] | r[12]);
			end
			rd(r[14] ? REG_STATUS : REG_TABLE_LO,
				r[14] ? st(1'b0) : tbl[31:0]);
			rd(r[14] ? REG_TABLE_LO : REG_STATUS,
				r[14] ? tbl[31:0] : st(1'b0));
			rd(REG_TABLE_HI, tbl[63:32]);
		end
		idle(3);
		conclude();
	end
endmodule
`default_nettype wire
